// [smd_params.svh]
// constants for the script move and i/o instruction decoder
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH

// ----------
// instruction fields
// ----------
`define SMD_TYPE_MSB 31
`define SMD_TYPE_LSB 30
`define SMD_IO_OPC_MSB 29
`define SMD_IO_OPC_LSB 27
`define SMD_MOVE_OPC_BIT 27
`define SMD_PHASE_MSB 26
`define SMD_PHASE_LSB 24
`define SMD_SEL_ATN_BIT 24
`define SMD_DEST_MSB 18
`define SMD_DEST_LSB 16
`define SMD_CARRY_BIT 10
`define SMD_TGT_BIT 9
`define SMD_ACK_BIT 6
`define SMD_ATN_BIT 3

// ----------
// encodings
// ----------
`define SMD_TYPE_MOVE 2'h0
`define SMD_TYPE_IO 2'h1
`define SMD_OPC_MOVE 1'h1
`define SMD_IO_SEL 3'h0
`define SMD_IO_DISC 3'h1
`define SMD_IO_WAIT 3'h2
`define SMD_IO_SET 3'h3
`define SMD_IO_CLR 3'h4
`define SMD_IO_RW_FIRST 3'h5
`define SMD_PH_RSV_OUT 3'h4
`define SMD_PH_RSV_IN 3'h5
`define SMD_ZERO_COUNT 24'h000000

// ----------
// timing
// ----------
`define SMD_CLK_NS 100
`define SMD_BUS_FREE_NS 400
`define SMD_BUS_FREE_CYC ((`SMD_BUS_FREE_NS + `SMD_CLK_NS - 1) / `SMD_CLK_NS)
`define SMD_FREE_CNT_W 3

`endif

// [smd_pkg.sv]
// types shared by the decoder, its assertions, the peer model and the bench
package smd_pkg;

    typedef struct packed {
        logic [31:0] cmd_count;
        logic [31:0] operand;
    } smd_instr_t;

    typedef struct packed {
        logic req;
        logic bsy;
        logic sel;
        logic msg;
        logic cd;
        logic io;
        logic arb_won;
        logic selected;
        logic reselected;
        logic sel_done;
    } smd_bus_in_t;

    typedef struct packed {
        logic ack;
        logic atn;
        logic arb;
        logic sel;
        logic [2:0] own_id;
        logic [2:0] dest_id;
    } smd_bus_out_t;

    typedef enum logic [3:0] {
        SMD_IDLE,
        SMD_MOVE_WAIT,
        SMD_MOVE_XFER,
        SMD_ARB,
        SMD_SELECT,
        SMD_WAIT_SEL,
        SMD_WAIT_RESEL,
        SMD_WAIT_DISC
    } smd_state_t;

endpackage

// [smd_bus_free_timer.sv]
// counts cycles with busy and select both idle
`include "smd_params.svh"

module smd_bus_free_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // bus state
    input wire logic arm_i,
    input wire logic bsy_i,
    input wire logic sel_i,
    // result
    output logic free_o
);
    import smd_pkg::*;

    logic [`SMD_FREE_CNT_W-1:0] cnt_ff;
    logic [`SMD_FREE_CNT_W-1:0] nxt_cnt;
    logic free_ff;
    wire idle_w = arm_i && !bsy_i && !sel_i;
    wire sat_w = (cnt_ff == `SMD_FREE_CNT_W'(`SMD_BUS_FREE_CYC));

    // any busy or select activity restarts the delay
    assign nxt_cnt = !idle_w ? '0 : (sat_w ? cnt_ff : cnt_ff + `SMD_FREE_CNT_W'(1));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_ff <= '0;
            free_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            free_ff <= idle_w && sat_w;
        end
    end

    assign free_o = free_ff;
endmodule

// [smd_decoder.sv]
// block move and i/o instruction decoder of the script engine
// ----------
// Notes on behaviour
// - move needs initiator mode; opcode one moves
// - move waits for request not yet acknowledged
// - latch phase lines on request, compare
// - matching phase moves count bytes from address
// - odd final wide byte held, merged next
// - phase mismatch interrupts, move not executed
// - three phase bits in 26-24
// - count loads, decrements to zero, then fetch
// - address word loads, increments per byte
// - i/o opcodes 101-111 are read/write
// - i/o opcode meaning depends on mode
// - arbitrate with own id, retry silently
// - after winning, select destination, fetch next
// - selected during arbitration jumps to alternate
// - select with attention asserts attention
// - target disconnect releases all bus outputs
// - wait select: selected continues, reselected jumps
// - signal process aborts select and reselect waits to alternate, not wait disconnect
// - wait disconnect needs 400 ns bus free
// - wait reselect: reselected continues, selected jumps
// - set/clear ack, atn, target, carry
// - target mode set/clear touches no bus signal
// - first word command and count, second operand
// - attention bit off select is illegal
// - destination id from bits 18-16
// - selector bits 10, 9, 6, 3
// ----------
`include "smd_params.svh"

module smd_decoder (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // instruction fetch side
    input wire logic instr_valid_i,
    input wire smd_pkg::smd_instr_t instr_i,
    output logic instr_ready_o,
    output logic fetch_next_o,
    output logic fetch_alt_o,
    output logic handoff_o,
    // control and status bits
    input wire logic [2:0] own_bus_id_reg_i,
    input wire logic signal_process_flag_i,
    input wire logic wide_i,
    input wire logic mode_wr_i,
    input wire logic mode_target_i,
    input wire logic disc_msg_i,
    output logic target_mode_o,
    output logic carry_o,
    output logic [1:0] output_control_latch_o,
    output logic [2:0] scsi_status_one_o,
    output logic phase_mismatch_o,
    output logic illegal_o,
    // data mover side
    input wire logic dma_beat_i,
    input wire logic [1:0] dma_bytes_i,
    output logic dma_req_o,
    output logic [23:0] byte_count_reg_o,
    output logic [31:0] next_address_reg_o,
    output logic [31:0] script_operand_reg_o,
    output logic [7:0] command_byte_reg_o,
    output logic residue_valid_o,
    output logic residue_rx_o,
    // scsi bus
    input wire smd_pkg::smd_bus_in_t bus_i,
    output smd_pkg::smd_bus_out_t bus_o
);
    import smd_pkg::*;

    function automatic logic [2:0] phase_of(input smd_bus_in_t b);
        phase_of = {b.msg, b.cd, b.io};
    endfunction

    // ----------
    // pin synchronisers
    // ----------
    smd_bus_in_t sync1_ff;
    smd_bus_in_t bus_s_ff;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_ff <= '0;
            bus_s_ff <= '0;
        end
        else
        begin
            sync1_ff <= bus_i;
            bus_s_ff <= sync1_ff;
        end
    end

    // ----------
    // state
    // ----------
    smd_state_t state_ff, nxt_state;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [23:0] count_ff, nxt_count;
    logic [31:0] addr_ff, nxt_addr;
    logic [31:0] oper_ff, nxt_oper;
    logic [2:0] phase_ff, nxt_phase;
    logic tgt_ff, nxt_tgt;
    logic carry_ff, nxt_carry;
    logic latch_ack_ff, nxt_latch_ack;
    logic latch_atn_ff, nxt_latch_atn;
    logic xack_ff, nxt_xack;
    logic res_ff, nxt_res;
    logic res_rx_ff, nxt_res_rx;
    logic next_ff, nxt_next;
    logic alt_ff, nxt_alt;
    logic hand_ff, nxt_hand;
    logic mis_ff, nxt_mis;
    logic ill_ff, nxt_ill;
    logic dma_ff, nxt_dma;
    logic arb_ff, nxt_arb;
    logic sel_ff, nxt_sel;
    logic sel_atn_ff, nxt_sel_atn;
    logic [2:0] dest_ff, nxt_dest;
    logic msg_seen_ff, nxt_msg_seen;
    logic bus_free, ready_ff;

    // ----------
    // instruction decode
    // ----------
    wire [31:0] w0 = instr_i.cmd_count;
    wire [1:0] itype_w = w0[`SMD_TYPE_MSB:`SMD_TYPE_LSB];
    wire [2:0] io_opc_w = w0[`SMD_IO_OPC_MSB:`SMD_IO_OPC_LSB];
    wire [2:0] iphase_w = w0[`SMD_PHASE_MSB:`SMD_PHASE_LSB];
    wire take_w = instr_valid_i && ready_ff;
    wire is_move_w = (itype_w == `SMD_TYPE_MOVE);
    wire is_io_w = (itype_w == `SMD_TYPE_IO) && (io_opc_w < `SMD_IO_RW_FIRST);
    wire rsv_phase_w = (iphase_w == `SMD_PH_RSV_OUT) || (iphase_w == `SMD_PH_RSV_IN);
    wire move_bad_w = tgt_ff || (w0[`SMD_MOVE_OPC_BIT] != `SMD_OPC_MOVE) || rsv_phase_w;
    wire atn_bad_w = w0[`SMD_SEL_ATN_BIT] && (tgt_ff || (io_opc_w != `SMD_IO_SEL));
    wire io_bad_w = atn_bad_w || (io_opc_w > `SMD_IO_CLR);
    wire set_w = (io_opc_w == `SMD_IO_SET);
    wire setclr_w = set_w || (io_opc_w == `SMD_IO_CLR);
    wire unserved_w = bus_s_ff.req && !xack_ff;
    wire ph_match_w = (phase_of(bus_s_ff) == cmd_ff[2:0]);
    wire [23:0] beat_w = (24'(dma_bytes_i) > count_ff) ? count_ff : 24'(dma_bytes_i);
    wire last_beat_w = (beat_w == count_ff);

    // ----------
    // next state
    // ----------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cmd = cmd_ff;
        nxt_count = count_ff;
        nxt_addr = addr_ff;
        nxt_oper = oper_ff;
        nxt_phase = phase_ff;
        nxt_tgt = tgt_ff;
        nxt_carry = carry_ff;
        nxt_latch_ack = latch_ack_ff;
        nxt_latch_atn = latch_atn_ff;
        nxt_xack = xack_ff;
        nxt_res = res_ff;
        nxt_res_rx = res_rx_ff;
        nxt_next = 1'b0;
        nxt_alt = alt_ff;
        nxt_hand = 1'b0;
        nxt_mis = 1'b0;
        nxt_ill = 1'b0;
        nxt_dma = 1'b0;
        nxt_arb = arb_ff;
        nxt_sel = sel_ff;
        nxt_sel_atn = sel_atn_ff;
        nxt_dest = dest_ff;
        nxt_msg_seen = msg_seen_ff;
        if (mode_wr_i)
        begin
            nxt_tgt = mode_target_i;
        end
        unique case (state_ff)
            SMD_IDLE:
            begin
                if (take_w)
                begin
                    nxt_cmd = w0[31:24];
                    nxt_count = w0[23:0];
                    nxt_oper = instr_i.operand;
                    nxt_addr = instr_i.operand;
                    nxt_dest = w0[`SMD_DEST_MSB:`SMD_DEST_LSB];
                    nxt_sel_atn = w0[`SMD_SEL_ATN_BIT];
                    if (is_move_w)
                    begin
                        if (move_bad_w)
                            nxt_ill = 1'b1;
                        else if (w0[23:0] == `SMD_ZERO_COUNT)
                        begin
                            nxt_next = 1'b1;
                            nxt_alt = 1'b0;
                        end
                        else
                            nxt_state = SMD_MOVE_WAIT;
                    end
                    else if (!is_io_w)
                        nxt_hand = 1'b1;
                    else if (io_bad_w)
                        nxt_ill = 1'b1;
                    else if (setclr_w)
                    begin
                        if (w0[`SMD_ACK_BIT])
                            nxt_latch_ack = set_w;
                        if (w0[`SMD_ATN_BIT])
                            nxt_latch_atn = set_w;
                        if (w0[`SMD_TGT_BIT])
                            nxt_tgt = set_w;
                        if (w0[`SMD_CARRY_BIT])
                            nxt_carry = set_w;
                        nxt_next = 1'b1;
                        nxt_alt = 1'b0;
                    end
                    else if (io_opc_w == `SMD_IO_SEL)
                        nxt_state = SMD_ARB;
                    else if (io_opc_w == `SMD_IO_DISC)
                    begin
                        if (tgt_ff)
                        begin
                            nxt_latch_ack = 1'b0;
                            nxt_latch_atn = 1'b0;
                            nxt_xack = 1'b0;
                            nxt_arb = 1'b0;
                            nxt_sel = 1'b0;
                            nxt_next = 1'b1;
                            nxt_alt = 1'b0;
                        end
                        else
                        begin
                            nxt_msg_seen = 1'b0;
                            nxt_state = SMD_WAIT_DISC;
                        end
                    end
                    else
                        nxt_state = tgt_ff ? SMD_WAIT_SEL : SMD_WAIT_RESEL;
                end
            end
            SMD_MOVE_WAIT:
            begin
                if (unserved_w)
                begin
                    nxt_phase = phase_of(bus_s_ff);
                    if (ph_match_w)
                        nxt_state = SMD_MOVE_XFER;
                    else
                    begin
                        nxt_mis = 1'b1;
                        nxt_state = SMD_IDLE;
                    end
                end
            end
            SMD_MOVE_XFER:
            begin
                nxt_dma = unserved_w && !dma_beat_i;
                if (unserved_w && dma_beat_i)
                begin
                    nxt_xack = 1'b1;
                    nxt_count = count_ff - beat_w;
                    nxt_addr = addr_ff + {8'h00, beat_w};
                    nxt_res = 1'b0;
                    if (last_beat_w && wide_i && beat_w[0])
                    begin
                        nxt_res = 1'b1;
                        nxt_res_rx = cmd_ff[0];
                    end
                end
                else if (!bus_s_ff.req && xack_ff)
                begin
                    nxt_xack = 1'b0;
                    if (count_ff == `SMD_ZERO_COUNT)
                    begin
                        nxt_next = 1'b1;
                        nxt_alt = 1'b0;
                        nxt_state = SMD_IDLE;
                    end
                    else
                        nxt_state = SMD_MOVE_WAIT;
                end
            end
            SMD_ARB:
            begin
                nxt_arb = 1'b1;
                if (bus_s_ff.selected || bus_s_ff.reselected)
                begin
                    nxt_arb = 1'b0;
                    nxt_next = 1'b1;
                    nxt_alt = 1'b1;
                    nxt_state = SMD_IDLE;
                end
                else if (arb_ff && bus_s_ff.arb_won)
                begin
                    nxt_arb = 1'b0;
                    nxt_sel = 1'b1;
                    nxt_state = SMD_SELECT;
                end
            end
            SMD_SELECT:
            begin
                if (bus_s_ff.sel_done)
                begin
                    nxt_sel = 1'b0;
                    nxt_next = 1'b1;
                    nxt_alt = 1'b0;
                    nxt_state = SMD_IDLE;
                end
            end
            SMD_WAIT_SEL:
            begin
                if (bus_s_ff.selected || bus_s_ff.reselected || signal_process_flag_i)
                begin
                    nxt_next = 1'b1;
                    nxt_alt = !bus_s_ff.selected;
                    nxt_state = SMD_IDLE;
                end
            end
            SMD_WAIT_RESEL:
            begin
                if (bus_s_ff.selected || bus_s_ff.reselected || signal_process_flag_i)
                begin
                    nxt_next = 1'b1;
                    nxt_alt = !bus_s_ff.reselected;
                    nxt_state = SMD_IDLE;
                end
            end
            SMD_WAIT_DISC:
            begin
                if (disc_msg_i)
                    nxt_msg_seen = 1'b1;
                if (bus_free)
                begin
                    nxt_next = 1'b1;
                    nxt_alt = 1'b0;
                    nxt_state = SMD_IDLE;
                end
            end
            default:
                nxt_state = SMD_IDLE;
        endcase
    end

    // ----------
    // registers
    // ----------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_ff <= SMD_IDLE;
            cmd_ff <= 8'h00;
            count_ff <= 24'h000000;
            addr_ff <= 32'h00000000;
            oper_ff <= 32'h00000000;
            phase_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            count_ff <= nxt_count;
            addr_ff <= nxt_addr;
            oper_ff <= nxt_oper;
            phase_ff <= nxt_phase;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tgt_ff <= 1'b0;
            carry_ff <= 1'b0;
            latch_ack_ff <= 1'b0;
            latch_atn_ff <= 1'b0;
            xack_ff <= 1'b0;
            res_ff <= 1'b0;
            res_rx_ff <= 1'b0;
            msg_seen_ff <= 1'b0;
        end
        else
        begin
            tgt_ff <= nxt_tgt;
            carry_ff <= nxt_carry;
            latch_ack_ff <= nxt_latch_ack;
            latch_atn_ff <= nxt_latch_atn;
            xack_ff <= nxt_xack;
            res_ff <= nxt_res;
            res_rx_ff <= nxt_res_rx;
            msg_seen_ff <= nxt_msg_seen;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            next_ff <= 1'b0;
            alt_ff <= 1'b0;
            hand_ff <= 1'b0;
            mis_ff <= 1'b0;
            ill_ff <= 1'b0;
            dma_ff <= 1'b0;
            arb_ff <= 1'b0;
            sel_ff <= 1'b0;
            sel_atn_ff <= 1'b0;
            dest_ff <= 3'h0;
        end
        else
        begin
            next_ff <= nxt_next;
            alt_ff <= nxt_alt;
            hand_ff <= nxt_hand;
            mis_ff <= nxt_mis;
            ill_ff <= nxt_ill;
            dma_ff <= nxt_dma;
            arb_ff <= nxt_arb;
            sel_ff <= nxt_sel;
            sel_atn_ff <= nxt_sel_atn;
            dest_ff <= nxt_dest;
        end
    end

    // ----------
    // bus drive, registered so outputs leave flops
    // ----------
    smd_bus_out_t bus_out_ff;
    smd_bus_out_t nxt_bus_out;

    // initiator-only lines stay released in target mode
    assign nxt_bus_out.ack = !nxt_tgt && (nxt_latch_ack || nxt_xack);
    assign nxt_bus_out.atn = !nxt_tgt && (nxt_latch_atn || (nxt_sel && nxt_sel_atn));
    assign nxt_bus_out.arb = nxt_arb;
    assign nxt_bus_out.sel = nxt_sel;
    assign nxt_bus_out.own_id = nxt_arb ? own_bus_id_reg_i : 3'h0;
    assign nxt_bus_out.dest_id = nxt_sel ? nxt_dest : 3'h0;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bus_out_ff <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            bus_out_ff <= nxt_bus_out;
            ready_ff <= (nxt_state == SMD_IDLE);
        end
    end

    // ----------
    // bus free delay
    // ----------
    smd_bus_free_timer u_free (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .arm_i(msg_seen_ff && (state_ff == SMD_WAIT_DISC)),
        .bsy_i(bus_s_ff.bsy),
        .sel_i(bus_s_ff.sel),
        .free_o(bus_free)
    );

    // ----------
    // outputs
    // ----------
    assign instr_ready_o = ready_ff;
    assign fetch_next_o = next_ff;
    assign fetch_alt_o = alt_ff;
    assign handoff_o = hand_ff;
    assign target_mode_o = tgt_ff;
    assign carry_o = carry_ff;
    assign output_control_latch_o = {latch_ack_ff, latch_atn_ff};
    assign scsi_status_one_o = phase_ff;
    assign phase_mismatch_o = mis_ff;
    assign illegal_o = ill_ff;
    assign dma_req_o = dma_ff;
    assign byte_count_reg_o = count_ff;
    assign next_address_reg_o = addr_ff;
    assign script_operand_reg_o = oper_ff;
    assign command_byte_reg_o = cmd_ff;
    assign residue_valid_o = res_ff;
    assign residue_rx_o = res_rx_ff;
    assign bus_o = bus_out_ff;
endmodule

// [smd_decoder_sva.sv]
// assertions on the ports of the decoder
module smd_decoder_sva
    import smd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // instruction and data mover side
    input wire logic instr_valid_i,
    input wire smd_pkg::smd_instr_t instr_i,
    input wire logic instr_ready_o,
    input wire logic fetch_next_o,
    input wire logic handoff_o,
    input wire logic [2:0] own_bus_id_reg_i,
    input wire logic carry_o,
    input wire logic illegal_o,
    input wire logic dma_beat_i,
    input wire logic [1:0] dma_bytes_i,
    input wire logic dma_req_o,
    input wire logic [23:0] byte_count_reg_o,
    input wire logic [31:0] next_address_reg_o,
    input wire logic [7:0] command_byte_reg_o,
    // scsi bus
    input wire smd_pkg::smd_bus_out_t bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire [4:0] top_w = instr_i.cmd_count[31:27];
    wire [31:0] w0_w = instr_i.cmd_count;
    wire beat_w = dma_req_o && dma_beat_i && dma_bytes_i <= byte_count_reg_o;
    sequence take_s;
        instr_valid_i && instr_ready_o;
    endsequence
    sequence take_io_s(o);
        take_s ##0 top_w == {2'h1, o} && !w0_w[24];
    endsequence
    chk_word_load: assert property (take_s ##0 top_w == 5'h01 |=>
        command_byte_reg_o == $past(w0_w[31:24])) else $error("command byte not loaded");
    chk_set_fetch: assert property (take_io_s(3'h3) |=> fetch_next_o && !illegal_o) else $error("set no fetch");
    chk_set_carry: assert property (take_io_s(3'h3) ##0 w0_w[10] |=> carry_o) else $error("carry not set");
    chk_atn_illegal: assert property (take_s ##0 top_w[4:3] == 2'h1 && top_w[2:0] inside {[1:4]} && w0_w[24]
        |=> illegal_o) else $error("attention bit accepted");
    chk_rw_handoff: assert property (take_s ##0 top_w[4:3] == 2'h1 && top_w[2:0] >= 3'h5 |=> handoff_o)
        else $error("read write not handed off");
    chk_phase_reserved: assert property (take_s ##0 top_w == 5'h01 && w0_w[26:25] == 2'h2 |=> illegal_o)
        else $error("reserved phase accepted");
    chk_arb_own_id: assert property (bus_o.arb |-> bus_o.own_id == own_bus_id_reg_i) else $error("own id");
    chk_count_step: assert property (beat_w |=> byte_count_reg_o == $past(byte_count_reg_o) - $past(dma_bytes_i))
        else $error("count step");
    chk_addr_step: assert property (beat_w |=> next_address_reg_o == $past(next_address_reg_o) + $past(dma_bytes_i))
        else $error("address step");
endmodule

bind smd_decoder smd_decoder_sva smd_decoder_sva_i (.*);

// [smd_scsi_peer.sv]
// far side model: a target that requests bytes and contends for the bus
module smd_scsi_peer (
    // clock
    input wire logic clk_i,
    // device outputs and bench commands
    input wire smd_pkg::smd_bus_out_t dev_i,
    input wire logic req_en_i,
    input wire logic [2:0] phase_i,
    input wire logic lose_i,
    input wire logic resel_i,
    // lines seen by the device
    output smd_pkg::smd_bus_in_t bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import smd_pkg::*;
    logic req_ff = 1'b0;
    logic [1:0] arb_cnt_ff = 2'h0;
    wire arb_done_w = arb_cnt_ff == 2'h3;
    // a new request only once ack is back low
    always @(posedge clk_i)
    begin
        req_ff <= req_en_i && !dev_i.ack;
        arb_cnt_ff <= !dev_i.arb ? 2'h0 : arb_done_w ? arb_cnt_ff : arb_cnt_ff + 2'h1;
    end
    // a lost contest shows as being selected
    assign bus_o = '{req_ff, req_en_i, 1'b0, phase_i[2], phase_i[1], phase_i[0], arb_done_w && !lose_i,
        arb_done_w && lose_i, resel_i, dev_i.sel};
endmodule

// [smd_decoder_bench.sv]
// self-checking bench for the decoder
module smd_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import smd_pkg::*;
    typedef struct packed { logic [31:0] w0; logic [5:0] exp; } smd_row_t;
    logic clk_i = 1'b0, arst_n_i = 1'b0, instr_valid_i = 1'b0, signal_process_flag_i = 1'b0, wide_i = 1'b1;
    logic mode_wr_i = 1'b0, mode_target_i = 1'b0, disc_msg_i = 1'b0, dma_beat_i = 1'b0, req_en = 1'b0, lose = 1'b0;
    logic resel = 1'b0;
    logic [2:0] own_bus_id_reg_i = 3'h6, phase = 3'h0;
    logic [1:0] dma_bytes_i = 2'h2;
    smd_instr_t instr_i = '0;
    logic instr_ready_o, fetch_next_o, fetch_alt_o, handoff_o, target_mode_o, carry_o, phase_mismatch_o, illegal_o;
    logic dma_req_o, residue_valid_o, residue_rx_o;
    logic [1:0] output_control_latch_o;
    logic [2:0] scsi_status_one_o;
    logic [23:0] byte_count_reg_o;
    logic [31:0] next_address_reg_o, script_operand_reg_o;
    smd_bus_in_t bus_i;
    smd_bus_out_t bus_o;
    int n_errors = 0, check_count = 0, cycles = 0, k = 0;
    // {fetch, illegal, handoff, carry, ack latch, atn latch}, in order from reset
    smd_row_t rows [13] = '{'{32'h58000400, 6'h24}, '{32'h58000048, 6'h27}, '{32'h60000040, 6'h25},
        '{32'h60000408, 6'h20}, '{32'h49000000, 6'h10}, '{32'h59000000, 6'h10}, '{32'h68000000, 6'h08},
        '{32'h78000000, 6'h08}, '{32'h80000000, 6'h08}, '{32'hC0000000, 6'h08}, '{32'h0C000010, 6'h10},
        '{32'h0D000010, 6'h10}, '{32'h00000010, 6'h10}};
    smd_decoder smd_decoder_i (.*, .command_byte_reg_o());
    smd_scsi_peer smd_scsi_peer_i (.clk_i(clk_i), .dev_i(bus_o), .req_en_i(req_en), .phase_i(phase),
        .lose_i(lose), .resel_i(resel), .bus_o(bus_i));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) dma_beat_i <= dma_req_o && !dma_beat_i;
    // a hang is cut short well past the expected run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // returns in the cycle where a one-cycle answer stands
    task automatic issue(input logic [31:0] w0, input logic [31:0] w1);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= '{w0, w1};
        do @(negedge clk_i); while (instr_ready_o !== 1'b1);
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic wait_fetch(input logic alt);
        for (k = 0; k < 300 && fetch_next_o !== 1'b1; k++) @(negedge clk_i);
        cmp({fetch_next_o, fetch_alt_o}, {1'b1, alt});
    endtask
    task automatic set_mode(input logic tgt);
        @(posedge clk_i);
        mode_wr_i <= 1'b1;
        mode_target_i <= tgt;
        @(posedge clk_i);
        mode_wr_i <= 1'b0;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        cmp({instr_ready_o, fetch_next_o, illegal_o, bus_o}, '0);
        arst_n_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        cmp(instr_ready_o, 1'b1);
        $display("reset test done");
        foreach (rows[i])
        begin
            issue(rows[i].w0, 32'h0);
            cmp({fetch_next_o, illegal_o, handoff_o, carry_o, output_control_latch_o}, rows[i].exp);
        end
        issue(32'h08000000, 32'h0);
        cmp(fetch_next_o, 1'b1);
        $display("table test done");
        @(posedge clk_i);
        phase <= 3'h1;
        req_en <= 1'b1;
        issue(32'h09000003, 32'h10000000);
        wait_fetch(1'b0);
        cmp({byte_count_reg_o, scsi_status_one_o, residue_valid_o, residue_rx_o}, {24'h0, 3'h1, 2'h3});
        cmp(next_address_reg_o, 32'h10000003);
        issue(32'h08000004, 32'h0);
        for (k = 0; k < 300 && phase_mismatch_o !== 1'b1; k++) @(negedge clk_i);
        cmp({phase_mismatch_o, fetch_next_o}, 2'h2);
        @(posedge clk_i);
        req_en <= 1'b0;
        $display("move test done");
        issue(32'h41050000, 32'h2000);
        for (k = 0; k < 300 && bus_o.sel !== 1'b1; k++) @(negedge clk_i);
        cmp({bus_o.atn, bus_o.dest_id}, 4'hD);
        wait_fetch(1'b0);
        @(posedge clk_i);
        lose <= 1'b1;
        issue(32'h40030000, 32'h3000);
        wait_fetch(1'b1);
        cmp({next_address_reg_o, script_operand_reg_o}, {2{32'h3000}});
        @(posedge clk_i) lose <= 1'b0;
        issue(32'h58000248, 32'h0);
        cmp({target_mode_o, output_control_latch_o, bus_o.ack, bus_o.atn}, 5'h1C);
        @(posedge clk_i) resel <= 1'b1;
        issue(32'h50000000, 32'h4000);
        wait_fetch(1'b1);
        @(posedge clk_i) resel <= 1'b0;
        issue(32'h48000000, 32'h0);
        wait_fetch(1'b0);
        cmp({output_control_latch_o, bus_o.ack, bus_o.atn, bus_o.arb, bus_o.sel}, 6'h0);
        issue(32'h09000001, 32'h0);
        cmp(illegal_o, 1'b1);
        set_mode(1'b0);
        $display("arbitration test done");
        issue(32'h50000000, 32'h5000);
        @(posedge clk_i) signal_process_flag_i <= 1'b1;
        wait_fetch(1'b1);
        @(posedge clk_i) signal_process_flag_i <= 1'b0;
        resel <= 1'b1;
        issue(32'h50000000, 32'h5000);
        wait_fetch(1'b0);
        @(posedge clk_i) resel <= 1'b0;
        issue(32'h48000000, 32'h0);
        @(posedge clk_i) disc_msg_i <= 1'b1;
        @(posedge clk_i);
        disc_msg_i <= 1'b0;
        wait_fetch(1'b0);
        cmp(k > 4, 1'b1);
        $display("wait test done");
        give_verdict();
    end
endmodule
